/* File: rtm_host_model.sv */
// Purpose: Host CPU on the four-wire serial port.
// Assumes: 15 ns serial clock, only running inside frames.
// Notes:   One access per frame; read data is reported by toggling rd_tgl.
`timescale 1ns/10ps
module rtm_host_model (
   input  wire logic       ref_clk,
   input  wire logic       so_out,
   input  wire logic       so_oe,
   output logic            ce,
   output logic            sclk,
   output logic            si,
   output logic [7:0]      rd_data,
   output logic            rd_tgl
);
   initial begin
      ce = 1'b0;
      sclk = 1'b0;
      si = 1'b0;
      rd_data = 8'h00;
      rd_tgl = 1'b0;
   end

   // Sparse accesses, one frame each
   task automatic xfer(input logic [3:0] addr, input logic rd,
                       input logic [7:0] wdata);
      logic [15:0] frame;
      logic [7:0]  got;
      frame = {addr, rd, 3'b101, wdata};
      got = 8'h00;
      @(posedge ref_clk);
      ce <= 1'b1;
      repeat (5) @(posedge ref_clk);
      #3;
      for (int i = 15; i >= 0; i--) begin
         si = frame[i];
         #7.5;
         if (i < 8) got = {got[6:0], so_oe ? so_out : 1'bx};
         sclk = 1'b1;
         #7.5;
         sclk = 1'b0;
      end
      @(posedge ref_clk);
      ce <= 1'b0;
      si = ~si;
      repeat (5) @(posedge ref_clk);
      if (rd) begin
         rd_data = got;
         rd_tgl = ~rd_tgl;
      end
   endtask : xfer
endmodule : rtm_host_model

/* File: rtm_pkg.sv */
// Purpose: Types shared by the trim and supply monitor block.
// Assumes: Nothing beyond the register header.
// Notes:   Types only.
package rtm_pkg;

   typedef enum logic [1:0] {
      LS_ADDR = 2'b00,
      LS_DATA = 2'b01,
      LS_DONE = 2'b10
   } rtm_link_state_t;

   typedef struct packed {
      logic       weekly_alarm_en;
      logic       daily_alarm_en;
      logic       hour_24_sel;
      logic       clkout_enable_b_n;
      logic       test_mode;
      logic [2:0] periodic_sel;
   } rtm_ctrl1_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
   } rtm_wr_t;

endpackage : rtm_pkg

/* File: rtm_regs.svh */
// Purpose: Offsets, field positions, reset values and timing for the
//          timebase trim and supply monitor block.
// Assumes: 50 MHz reference clock, 32.768 kHz crystal sampled as a pin.
// Notes:   Definitions only.
// Notes on behaviour
// - Non-neutral trim alters one second's count per 20-second window.
// - Trim is off when trim bits 5 down to 1 are all zero.
// - 7-bit signed trim code; fast-oscillator values count up from 01h.
// - Slow-oscillator codes are 128 minus magnitude, down from 80h.
// - Codes for 0, +1, -64 and -63 give no net correction.
// - Trim touches only second counting, never the crystal clock output.
// - Writing 03h to control register 1 gives a 1 Hz pulse on irq pin.
// - Supply threshold is 2.1 V when select is 0, 1.6 V when 1.
// - Halt and low-supply flags: sticky, high active, cleared by writing 0; low-supply also cleared while halt flag is 1.
// - At power-up the halt flag is 1 and the low-supply flag 0.
// - Halt sensing runs only while chip enable is low; result is held.
// - Flags 00 no fault, 01 supply drop, 1x oscillator halt.
// - While halt flag is 1, trim and listed control bits are forced to 0.
// - Supply comparator samples for 7.8 ms once per second.
// - Supply sampling stops while the low-supply flag is 1.
// - Periodic output period varies by at most 3.784 ms every 20 seconds.
`ifndef RTM_REGS_SVH
`define RTM_REGS_SVH

`define RTM_ADDR_TRIM       4'h7
`define RTM_ADDR_CTRL1      4'hE
`define RTM_ADDR_CTRL2      4'hF

`define RTM_TRIM_RESET      7'h00
`define RTM_CTRL1_RESET     8'h00
`define RTM_CTRL2_RESET     8'h20

`define RTM_C2_THRESH_BIT   7
`define RTM_C2_LOW_BIT      6
`define RTM_C2_HALT_BIT     5
`define RTM_C2_SPARE_BIT    4
`define RTM_C2_CLKA_BIT     3
`define RTM_C2_PIRQ_BIT     2
`define RTM_C2_WALM_BIT     1
`define RTM_C2_DALM_BIT     0

`define RTM_PER_OFF         3'h0
`define RTM_PER_LOW         3'h1
`define RTM_PER_2HZ         3'h2
`define RTM_PER_1HZ         3'h3

`define RTM_XTAL_HZ         17'h08000
`define RTM_HALF_SEC        16'h4000
`define RTM_TRIM_WINDOW_S   5'h14
`define RTM_TRIM_STEP       17'h00002

`define RTM_REF_MHZ         50
`define RTM_SAMPLE_US       7800
`define RTM_SAMPLE_CYCLES   (`RTM_SAMPLE_US * `RTM_REF_MHZ)
`define RTM_HALT_US         1000
`define RTM_HALT_CYCLES     (`RTM_HALT_US * `RTM_REF_MHZ)

`endif

/* File: rtm_sync.sv */
// Purpose: Two-flop synchroniser for a group of slow levels.
// Assumes: Each bit is an independent level.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/10ps
module rtm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : rtm_sync

/* File: rtm_trim_monitor.sv */
// Purpose: Timebase trim, oscillator halt sensing and supply monitoring
//          behind a four-wire serial register port.
// Assumes: Host waits at least four ref_clk cycles after chip enable
//          rises before the first serial clock edge.
// Notes:   Serial logic runs on the serial clock; writes cross by toggle.
`timescale 1ns/10ps
`include "rtm_regs.svh"
module rtm_trim_monitor
   import rtm_pkg::*;
#(
   parameter int SAMPLE_CYCLES = `RTM_SAMPLE_CYCLES,
   parameter int HALT_CYCLES   = `RTM_HALT_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic osc_in,
   input  wire logic below_2v1,
   input  wire logic below_1v6,
   input  wire logic ce,
   input  wire logic sclk,
   input  wire logic si,
   output logic      so_out,
   output logic      so_oe,
   output logic      irq_out_n,
   output logic      crystal_clock_out,
   output logic      second_pulse,
   output logic      supply_sample_en
);

   // Reference domain state
   logic [3:0]  pins_s;
   logic        ce_s;
   logic        osc_s;
   logic        osc_d;
   logic        osc_rise;
   logic        wr_tgl_s;
   logic        wr_tgl_d;
   logic        wr_evt;
   logic [6:0]  trim_code;
   rtm_ctrl1_t  ctrl1;
   logic        supply_threshold_sel;
   logic        low_supply_flag;
   logic        osc_halt_flag;
   logic        spare_bits;
   logic        clkout_enable_a_n;
   logic        periodic_irq_flag;
   logic        weekly_alarm_flag;
   logic        daily_alarm_flag;
   logic [7:0]  ctrl2_word;
   logic [15:0] sub_cnt;
   logic [4:0]  win_sec;
   logic        trim_active;
   logic [16:0] sec_len;
   logic [16:0] next_sec_len;
   logic        sec_end;
   logic [31:0] halt_cnt;
   logic        halt_evt;
   logic [31:0] samp_cnt;
   logic        below_sel;
   logic        low_evt;
   logic        wr_ctrl2;
   logic [7:0]  shadow_trim;
   logic [7:0]  shadow_c1;
   logic [7:0]  shadow_c2;

   // Serial domain state
   logic            frame_rst_n;
   rtm_link_state_t lstate;
   logic [2:0]      bit_cnt;
   logic [6:0]      in_sh;
   logic [7:0]      in_byte;
   logic [3:0]      rd_addr;
   logic            rd_mode;
   logic [6:0]      out_sh;
   logic [7:0]      rd_byte;
   rtm_wr_t         wr_word;
   logic            wr_tgl;

   // ---------------------------------------------------------------
   // Pin and write-toggle synchronisers
   rtm_sync #(.W(4)) u_pin_sync (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .d      ({ce, osc_in, below_2v1, below_1v6}),
      .q      (pins_s)
   );

   rtm_sync #(.W(1)) u_wr_sync (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .d      (wr_tgl),
      .q      (wr_tgl_s)
   );

   assign ce_s  = pins_s[3];
   assign osc_s = pins_s[2];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_d    <= 1'b0;
         wr_tgl_d <= 1'b0;
      end else begin
         osc_d    <= osc_s;
         wr_tgl_d <= wr_tgl_s;
      end
   end

   assign osc_rise = osc_s & ~osc_d;
   assign wr_evt   = wr_tgl_s ^ wr_tgl_d;
   assign wr_ctrl2 = wr_evt && (wr_word.addr == `RTM_ADDR_CTRL2);

   // ---------------------------------------------------------------
   // Trim decode and second length
   assign trim_active = (trim_code[5:1] != 5'h00);

   always_comb begin
      if (!trim_code[6]) begin
         next_sec_len = `RTM_XTAL_HZ
            + 17'(`RTM_TRIM_STEP * 17'(trim_code - 7'h01));
      end else begin
         next_sec_len = `RTM_XTAL_HZ
            - 17'(`RTM_TRIM_STEP * 17'(8'h80 - {1'b0, trim_code}));
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sec_len <= `RTM_XTAL_HZ;
      end else if (trim_active
                   && win_sec == `RTM_TRIM_WINDOW_S - 5'h01) begin
         sec_len <= next_sec_len;
      end else begin
         sec_len <= `RTM_XTAL_HZ;
      end
   end

   assign sec_end = osc_rise && ({1'b0, sub_cnt} >= sec_len - 17'h00001);

   // Second counting; the crystal output never sees this counter
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sub_cnt      <= 16'h0000;
         win_sec      <= 5'h00;
         second_pulse <= 1'b0;
      end else begin
         second_pulse <= sec_end;
         if (sec_end) begin
            sub_cnt <= 16'h0000;
            if (win_sec == `RTM_TRIM_WINDOW_S - 5'h01) begin
               win_sec <= 5'h00;
            end else begin
               win_sec <= win_sec + 5'h01;
            end
         end else if (osc_rise) begin
            sub_cnt <= sub_cnt + 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Periodic output; in 1 Hz mode a trimmed second changes only the low half
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_out_n <= 1'b1;
      end else begin
         unique case (ctrl1.periodic_sel)
            `RTM_PER_LOW: irq_out_n <= 1'b0;
            `RTM_PER_2HZ: irq_out_n <= ~sub_cnt[13];
            `RTM_PER_1HZ: irq_out_n <= (sub_cnt < `RTM_HALF_SEC);
            default:      irq_out_n <= 1'b1;
         endcase
      end
   end

   // Crystal clock passes untrimmed
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         crystal_clock_out <= 1'b0;
      end else begin
         crystal_clock_out <= osc_s
            & ~(clkout_enable_a_n & ctrl1.clkout_enable_b_n);
      end
   end

   // ---------------------------------------------------------------
   // Oscillator halt sensing, active only with chip enable low
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         halt_cnt <= 32'h00000000;
      end else if (ce_s || osc_rise) begin
         halt_cnt <= 32'h00000000;
      end else if (halt_cnt < 32'(HALT_CYCLES - 1)) begin
         halt_cnt <= halt_cnt + 32'h00000001;
      end
   end

   assign halt_evt = !ce_s && (halt_cnt == 32'(HALT_CYCLES - 1));

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_halt_flag <= 1'b1;
      end else if (halt_evt) begin
         osc_halt_flag <= 1'b1;
      end else if (wr_ctrl2 && !wr_word.data[`RTM_C2_HALT_BIT]) begin
         osc_halt_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Supply sampling window, one per second
   assign below_sel = supply_threshold_sel ? pins_s[0] : pins_s[1];
   assign low_evt   = supply_sample_en && below_sel;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         supply_sample_en <= 1'b0;
         samp_cnt         <= 32'h00000000;
      end else if (low_supply_flag || low_evt) begin
         supply_sample_en <= 1'b0;
         samp_cnt         <= 32'h00000000;
      end else if (sec_end) begin
         supply_sample_en <= 1'b1;
         samp_cnt         <= 32'h00000000;
      end else if (supply_sample_en) begin
         if (samp_cnt == 32'(SAMPLE_CYCLES - 1)) begin
            supply_sample_en <= 1'b0;
         end
         samp_cnt <= samp_cnt + 32'h00000001;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         low_supply_flag <= 1'b0;
      end else if (osc_halt_flag) begin
         low_supply_flag <= 1'b0;
      end else if (low_evt) begin
         low_supply_flag <= 1'b1;
      end else if (wr_ctrl2 && !wr_word.data[`RTM_C2_LOW_BIT]) begin
         low_supply_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Trim and control registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         trim_code <= `RTM_TRIM_RESET;
      end else if (osc_halt_flag) begin
         trim_code <= `RTM_TRIM_RESET;
      end else if (wr_evt && wr_word.addr == `RTM_ADDR_TRIM) begin
         trim_code <= wr_word.data[6:0];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl1 <= rtm_ctrl1_t'(`RTM_CTRL1_RESET);
      end else if (osc_halt_flag) begin
         ctrl1 <= rtm_ctrl1_t'(`RTM_CTRL1_RESET);
      end else if (wr_evt && wr_word.addr == `RTM_ADDR_CTRL1) begin
         ctrl1 <= rtm_ctrl1_t'(wr_word.data);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         supply_threshold_sel <= 1'b0;
         spare_bits           <= 1'b0;
         clkout_enable_a_n    <= 1'b0;
      end else if (osc_halt_flag) begin
         supply_threshold_sel <= 1'b0;
         spare_bits           <= 1'b0;
         clkout_enable_a_n    <= 1'b0;
      end else if (wr_ctrl2) begin
         supply_threshold_sel <= wr_word.data[`RTM_C2_THRESH_BIT];
         spare_bits           <= wr_word.data[`RTM_C2_SPARE_BIT];
         clkout_enable_a_n    <= wr_word.data[`RTM_C2_CLKA_BIT];
      end
   end

   // Interrupt flags have no set path anywhere, so they stay 0; write 0 clears
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         periodic_irq_flag <= 1'b0;
         weekly_alarm_flag <= 1'b0;
         daily_alarm_flag  <= 1'b0;
      end else if (osc_halt_flag) begin
         periodic_irq_flag <= 1'b0;
         weekly_alarm_flag <= 1'b0;
         daily_alarm_flag  <= 1'b0;
      end else if (wr_ctrl2) begin
         periodic_irq_flag <= periodic_irq_flag
                              & wr_word.data[`RTM_C2_PIRQ_BIT];
         weekly_alarm_flag <= weekly_alarm_flag
                              & wr_word.data[`RTM_C2_WALM_BIT];
         daily_alarm_flag  <= daily_alarm_flag
                              & wr_word.data[`RTM_C2_DALM_BIT];
      end
   end

   assign ctrl2_word = {supply_threshold_sel, low_supply_flag,
                        osc_halt_flag, spare_bits, clkout_enable_a_n,
                        periodic_irq_flag, weekly_alarm_flag,
                        daily_alarm_flag};

   // Snapshot frozen while chip enable is high, read by the serial side
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shadow_trim <= 8'h00;
         shadow_c1   <= `RTM_CTRL1_RESET;
         shadow_c2   <= `RTM_CTRL2_RESET;
      end else if (!ce_s) begin
         shadow_trim <= {1'b0, trim_code};
         shadow_c1   <= ctrl1;
         shadow_c2   <= ctrl2_word;
      end
   end

   // ---------------------------------------------------------------
   // Serial port on the serial clock; frame cleared while ce is low
   assign frame_rst_n = arst_n & ce;
   assign in_byte     = {in_sh, si};

   always_comb begin
      unique case (in_byte[7:4])
         `RTM_ADDR_TRIM:  rd_byte = shadow_trim;
         `RTM_ADDR_CTRL1: rd_byte = shadow_c1;
         `RTM_ADDR_CTRL2: rd_byte = shadow_c2;
         default:         rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         lstate  <= LS_ADDR;
         bit_cnt <= 3'h0;
         in_sh   <= 7'h00;
         rd_addr <= 4'h0;
         rd_mode <= 1'b0;
         out_sh  <= 7'h00;
         so_out  <= 1'b0;
         so_oe   <= 1'b0;
      end else begin
         in_sh   <= in_byte[6:0];
         bit_cnt <= bit_cnt + 3'h1;
         unique case (lstate)
            LS_ADDR: begin
               if (bit_cnt == 3'h7) begin
                  lstate  <= LS_DATA;
                  rd_addr <= in_byte[7:4];
                  rd_mode <= in_byte[3];
                  so_oe   <= in_byte[3];
                  so_out  <= in_byte[3] & rd_byte[7];
                  out_sh  <= rd_byte[6:0];
               end
            end
            LS_DATA: begin
               so_out <= rd_mode & out_sh[6];
               out_sh <= {out_sh[5:0], 1'b0};
               if (bit_cnt == 3'h7) begin
                  lstate <= LS_DONE;
                  so_oe  <= 1'b0;
               end
            end
            LS_DONE: begin
               so_oe <= 1'b0;
            end
            default: lstate <= LS_DONE;
         endcase
      end
   end

   // Write word stays stable until the next frame's write completes
   always_ff @(posedge sclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_word <= '0;
         wr_tgl  <= 1'b0;
      end else if (lstate == LS_DATA && bit_cnt == 3'h7 && !rd_mode
                   && frame_rst_n) begin
         wr_word <= {rd_addr, in_byte};
         wr_tgl  <= ~wr_tgl;
      end
   end

endmodule : rtm_trim_monitor

/* File: rtm_trim_monitor_asserts.sv */
// Purpose: Port-level checks for the trim and supply monitor block.
// Assumes: Sees only the top module ports; bound below.
// Notes:   Only the read-timing check runs on sclk, the rest on ref_clk.
`timescale 1ns/10ps
module rtm_trim_monitor_asserts #(
   parameter int SAMPLE_CYCLES = 100,
   parameter int HALT_CYCLES   = 200
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic osc_in,
   input wire logic below_2v1,
   input wire logic below_1v6,
   input wire logic ce,
   input wire logic sclk,
   input wire logic si,
   input wire logic so_out,
   input wire logic so_oe,
   input wire logic irq_out_n,
   input wire logic crystal_clock_out,
   input wire logic second_pulse,
   input wire logic supply_sample_en
);
   logic [31:0] sample_run;
   logic        osc_prev;
   logic [3:0]  osc_quiet;
   logic [4:0]  sclk_edges;

   // Length of the current sampling window so far
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) sample_run <= 32'h0;
      else if (supply_sample_en) sample_run <= sample_run + 32'h1;
      else sample_run <= 32'h0;
   end

   // Cycles since the crystal pin last changed, saturating
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) osc_prev <= 1'b0;
      else osc_prev <= osc_in;
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) osc_quiet <= 4'h0;
      else if (osc_in != osc_prev) osc_quiet <= 4'h0;
      else if (osc_quiet != 4'hF) osc_quiet <= osc_quiet + 4'h1;
   end

   // Serial clock edges within the current frame
   always_ff @(posedge sclk or negedge ce or negedge arst_n) begin
      if (!arst_n || !ce) sclk_edges <= 5'h00;
      else if (sclk_edges != 5'h1F) sclk_edges <= sclk_edges + 5'h01;
   end

   sequence s_ce_idle;
      !ce ##1 !ce;
   endsequence
   sequence s_window_end;
      $fell(supply_sample_en);
   endsequence

   AST_PULSE_SINGLE: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      second_pulse |=> !second_pulse) else $error("second pulse too long");
   AST_SECOND_ON_OSC: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      second_pulse |-> osc_quiet < 4'h8) else $error("second without crystal");
   AST_SAMPLE_BOUND: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      supply_sample_en |-> sample_run < SAMPLE_CYCLES)
      else $error("sampling window too long");
   AST_SAMPLE_AT_SECOND: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      $rose(supply_sample_en) |->
         (second_pulse || $past(second_pulse) || $past(second_pulse, 2)))
      else $error("window opened off a second end");
   AST_SAMPLE_GAP: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      s_window_end |=> !supply_sample_en [*8]) else $error("window reopened");
   AST_CLKOUT_FOLLOWS: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      $rose(crystal_clock_out) |->
         ($past(osc_in, 2) || $past(osc_in, 3) || $past(osc_in, 4)))
      else $error("clock output rose without crystal");
   AST_SO_OE_IDLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
      s_ce_idle |-> !so_oe) else $error("serial out driven outside frame");
   AST_READ_AT_EIGHT: assert property (@(posedge sclk) disable iff (!arst_n)
      $rose(so_oe) |-> sclk_edges == 5'h08)
      else $error("read data not after address byte");
endmodule : rtm_trim_monitor_asserts

bind rtm_trim_monitor rtm_trim_monitor_asserts #(
   .SAMPLE_CYCLES(SAMPLE_CYCLES),
   .HALT_CYCLES(HALT_CYCLES)
) u_asserts (
   .ref_clk(ref_clk), .arst_n(arst_n), .osc_in(osc_in),
   .below_2v1(below_2v1), .below_1v6(below_1v6), .ce(ce), .sclk(sclk),
   .si(si), .so_out(so_out), .so_oe(so_oe), .irq_out_n(irq_out_n),
   .crystal_clock_out(crystal_clock_out), .second_pulse(second_pulse),
   .supply_sample_en(supply_sample_en)
);

/* File: rtm_trim_monitor_bench.sv */
// Purpose: Self-checking bench for the trim and supply monitor block.
// Assumes: Crystal pin toggles every ref_clk cycle to shorten a second.
// Notes:   Reads are checked by a watcher against a queue of notes.
`timescale 1ns/10ps
module rtm_trim_monitor_bench;
   import rtm_pkg::*;
   localparam int SAMPLE = 100;
   localparam logic [7:0] CODES [7] = '{8'h09, 8'h46, 8'h00, 8'h01,
                                        8'h40, 8'h41, 8'hBF};
   logic       ref_clk, arst_n, osc_in, osc_run, below_2v1, below_1v6;
   logic       ce, sclk, si, so_out, so_oe, irq_out_n, crystal_clock_out;
   logic       second_pulse, supply_sample_en, rd_tgl, seen;
   logic [7:0] rd_data;
   logic [31:0] lfsr;
   logic [7:0] expq [$];
   int         miscompares, checked, len;
   time        t_rise;

   rtm_trim_monitor #(.SAMPLE_CYCLES(SAMPLE), .HALT_CYCLES(200)) uut (
      .ref_clk(ref_clk), .arst_n(arst_n), .osc_in(osc_in),
      .below_2v1(below_2v1), .below_1v6(below_1v6), .ce(ce), .sclk(sclk),
      .si(si), .so_out(so_out), .so_oe(so_oe), .irq_out_n(irq_out_n),
      .crystal_clock_out(crystal_clock_out), .second_pulse(second_pulse),
      .supply_sample_en(supply_sample_en));
   rtm_host_model host (.ref_clk(ref_clk), .so_out(so_out), .so_oe(so_oe),
      .ce(ce), .sclk(sclk), .si(si), .rd_data(rd_data), .rd_tgl(rd_tgl));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
      checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s got %h want %h", $time, what,
                  got, exp);
         miscompares++;
      end
   endtask : check

   task automatic limit(input int n, input int lim);
      if (n >= lim) begin
         $display("wrong value at %0t: wait ran out", $time);
         miscompares++;
         give_verdict();
      end
   endtask : limit

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      host.xfer(a, 1'b0, d);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      expq.push_back(e);
      host.xfer(a, 1'b1, 8'h00);
   endtask : rd

   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cycles

   // Read results against the oldest note
   always @(rd_tgl) begin
      if (arst_n === 1'b1) begin
         if (expq.size() == 0)
            check(8'h00, 8'hFF, "unexpected read");
         else
            check(rd_data, expq.pop_front(), "register read");
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) if (osc_run) osc_in <= ~osc_in;

   initial begin
      arst_n = 1'b0;
      osc_in = 1'b0;
      osc_run = 1'b1;
      below_2v1 = 1'b0;
      below_1v6 = 1'b0;
      lfsr = 32'hBACB;
      miscompares = 0;
      checked = 0;
      cycles(16);
      arst_n <= 1'b1;
      cycles(4);
      rd(4'hF, 8'h20);
      rd(4'h7, 8'h00);
      wr(4'h7, 8'h09);
      wr(4'hE, 8'h03);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h20);
      rd(4'h7, 8'h00);
      rd(4'hE, 8'h00);
      wr(4'hF, 8'h00);
      rd(4'hF, 8'h00);
      wr(4'h3, 8'hFF);
      rd(4'h3, 8'h00);
      $display("test power-up and halt forcing done");
      foreach (CODES[i]) begin
         wr(4'h7, CODES[i]);
         rd(4'h7, CODES[i] & 8'h7F);
      end
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         wr(4'h7, lfsr[7:0]);
         rd(4'h7, lfsr[7:0] & 8'h7F);
      end
      $display("test trim codes done");
      for (int m = 0; m < 3; m++) begin
         wr(4'hE, (m == 0) ? 8'h01 : (m == 1) ? 8'h00 : 8'h04);
         cycles(2);
         check({7'h00, irq_out_n}, {7'h00, m != 0}, "irq mode");
      end
      wr(4'hE, 8'h10);
      wr(4'hF, 8'h08);
      seen = 1'b0;
      repeat (16) @(posedge ref_clk) seen = seen | crystal_clock_out;
      check({7'h00, seen}, 8'h00, "clock output off");
      wr(4'hE, 8'h03);
      wr(4'hF, 8'h80);
      seen = 1'b0;
      repeat (16) @(posedge ref_clk) seen = seen | crystal_clock_out;
      check({7'h00, seen}, 8'h01, "clock output on");
      $display("test output modes done");
      below_2v1 <= 1'b1;
      len = 0;
      while (second_pulse !== 1'b1 && len < 70000) begin
         cycles(1);
         len++;
      end
      limit(len, 70000);
      len = 0;
      while (supply_sample_en !== 1'b1 && len < 8) begin
         cycles(1);
         len++;
      end
      limit(len, 8);
      t_rise = $time;
      cycles(30);
      check({7'h00, supply_sample_en}, 8'h01, "window at 1.6 V");
      check({7'h00, irq_out_n}, 8'h01, "1 Hz first half");
      wr(4'hF, 8'h00);
      len = 0;
      while (supply_sample_en === 1'b1 && len < SAMPLE) begin
         cycles(1);
         len++;
      end
      check({7'h00, ($time - t_rise) < 1800}, 8'h01, "window cut");
      below_2v1 <= 1'b0;
      rd(4'hF, 8'h40);
      wr(4'hF, 8'h40);
      rd(4'hF, 8'h40);
      wr(4'hF, 8'h00);
      rd(4'hF, 8'h00);
      $display("test supply monitor done");
      cycles(16500);
      wr(4'hE, 8'h02);
      check({7'h00, irq_out_n}, 8'h00, "2 Hz second quarter");
      wr(4'hE, 8'h03);
      cycles(16200);
      check({7'h00, irq_out_n}, 8'h00, "1 Hz second half");
      osc_run <= 1'b0;
      cycles(400);
      osc_run <= 1'b1;
      rd(4'hF, 8'h20);
      rd(4'hE, 8'h00);
      rd(4'h7, 8'h00);
      check({7'h00, irq_out_n}, 8'h01, "irq after halt");
      $display("test oscillator halt done");
      cycles(4);
      give_verdict();
   end
endmodule : rtm_trim_monitor_bench
